// ===== rtl/drive_monitor_map.svh
// Register indices, field positions, reset values and timing counts of the drive monitor.
// Assumes the includer imports nothing from it but macros; no logic lives here.
`ifndef DRIVE_MONITOR_MAP_SVH
`define DRIVE_MONITOR_MAP_SVH

// Register indices; the byte address on the bus is four times the index.
`define IDX_IRQ_FLAGS     16'h1302
`define IDX_ALARM_STATE   16'h1303
`define IDX_TX_CONTROL    16'h1304
`define IDX_IRQ_MASK      16'h1305

// Field positions.
`define BIT_DRIVE_CHANGE  0
`define BIT_DRIVE_FAULT   0
`define BIT_BUILD_OUT     0
`define BIT_SEND_ONES     2
`define BIT_INTERNAL_MON  5

// Reset values.
`define RST_TX_CONTROL    8'h00
`define RST_IRQ_MASK      8'h01

// Timing: clock period and line bit period, both in ns, and the divider derived from them.
`define CLK_PERIOD_NS     20
`define BIT_PERIOD_NS     20
`define BIT_DIV           (`BIT_PERIOD_NS / `CLK_PERIOD_NS)
`define SILENT_BITS       128

// Bus responses.
`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10

`endif

// ===== rtl/drive_monitor_pkg.sv
// Types shared by the transmit drive monitor.
// Assumes drive_monitor_map.svh provides all numeric constants.
package drive_monitor_pkg;

    // Software-written transmit control fields.
    typedef struct packed {
        logic internal_mon;
        logic send_all_ones;
        logic build_out_disable;
    } tx_ctrl_t;

    // One bipolar line sample: positive and negative rail.
    typedef struct packed {
        logic pos;
        logic neg;
    } bipolar_t;

    // Drive monitor condition.
    typedef enum logic {
        LINE_ACTIVE,
        LINE_SILENT
    } mon_state_t;

endpackage : drive_monitor_pkg

// ===== rtl/transmit_drive_monitor.sv
// Transmit drive monitor with its AXI4-Lite register slave and change interrupt.
// Assumes one 50 MHz clock, synchronous active-low reset, and asynchronous line inputs.
// Function
// - In external mode the monitor watches the two monitor input pins for bipolar pulses.
// - While pulses keep arriving the drive-fault bit 0 of the alarm register stays zero.
// - After about 128 bit periods with no pulse at all the drive fault is declared.
// - Declaring the drive fault sets bit 0 of the alarm register to one.
// - While mask bit 0 of the interrupt mask register is set, every drive-fault change raises the interrupt by pulling the active-low request low.
// - Every drive-fault change sets change flag bit 0 of the interrupt flag register.
// - A declared drive fault clears as soon as one bipolar pulse is seen.
// - Clearing the fault returns alarm bit 0 to zero and raises the change interrupt again while mask bit 0 is set.
// - With bit 5 set the monitor watches the transmit output pads instead of the pins.
`timescale 1ns/10ps

`include "drive_monitor_map.svh"

module transmit_drive_monitor
    import drive_monitor_pkg::*;
(
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address
    input  wire logic [15:0] s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [15:0] s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Monitor input pins, looped from the transmit line
    input  wire logic        monitor_pos_in,
    input  wire logic        monitor_neg_in,
    // Sense of the transmit output pads
    input  wire logic        line_out_pos,
    input  wire logic        line_out_neg,
    // Transmitter controls
    output logic             build_out_disable,
    output logic             send_all_ones,
    // Status and interrupt
    output logic             drive_fault,
    output logic             irq_n
);

    localparam logic [7:0] BIT_DIV_LAST   = 8'(`BIT_DIV - 1);
    localparam logic [7:0] SILENT_LAST    = 8'(`SILENT_BITS - 1);
    // Reset words live in parameters so that single fields can be selected from them.
    localparam logic [7:0] TX_CTRL_RST    = `RST_TX_CONTROL;
    localparam logic [7:0] IRQ_MASK_RST   = `RST_IRQ_MASK;

    // Address decode, shared by the read and write paths.
    function automatic logic [15:0] reg_index(input logic [15:0] addr);
        reg_index = {2'b00, addr[15:2]};
    endfunction : reg_index

    function automatic logic is_mapped(input logic [15:0] addr);
        logic [15:0] idx;
        idx = reg_index(addr);
        is_mapped = (addr[1:0] == 2'b00) &&
                    (idx == `IDX_IRQ_FLAGS || idx == `IDX_ALARM_STATE ||
                     idx == `IDX_TX_CONTROL || idx == `IDX_IRQ_MASK);
    endfunction : is_mapped

    // Input synchronisers: pads on the high pair, monitor pins on the low.
    logic [3:0] line_raw;
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;

    assign line_raw = {line_out_pos, line_out_neg, monitor_pos_in, monitor_neg_in};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
        end else begin
            sync1_q <= line_raw;
            sync2_q <= sync1_q;
        end
    end

    // Register state.
    tx_ctrl_t   ctrl_q, ctrl_d;
    logic       mask_q, mask_d;
    logic       flag_q, flag_d;

    // Source selection and bipolar pulse detection.
    bipolar_t   watched;
    logic       pulse_now;

    always_comb begin
        if (ctrl_q.internal_mon) begin
            watched = '{pos: sync2_q[3], neg: sync2_q[2]};
        end else begin
            watched = '{pos: sync2_q[1], neg: sync2_q[0]};
        end
        pulse_now = watched.pos | watched.neg;
    end

    // Bit-period enable from a divider of the system clock.
    logic [7:0] div_q, div_d;
    logic       bit_en;

    always_comb begin
        bit_en = (div_q == BIT_DIV_LAST);
        div_d  = bit_en ? 8'h00 : div_q + 8'h01;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_q <= 8'h00;
        end else begin
            div_q <= div_d;
        end
    end

    // Silence counter and fault state.
    mon_state_t state_q, state_d;
    logic [7:0] silent_q, silent_d;
    logic       seen_q, seen_d;
    logic       mode_write;
    logic       change;

    always_comb begin
        state_d  = state_q;
        silent_d = silent_q;
        seen_d   = seen_q | pulse_now;
        change   = 1'b0;
        if (mode_write) begin
            // A source change restarts the count so the old source cannot leak in.
            silent_d = 8'h00;
            seen_d   = 1'b0;
        end else if (bit_en) begin
            seen_d = 1'b0;
            if (seen_q || pulse_now) begin
                silent_d = 8'h00;
            end else if (silent_q != SILENT_LAST) begin
                silent_d = silent_q + 8'h01;
            end
        end
        unique case (state_q)
            LINE_ACTIVE: begin
                if (!mode_write && bit_en && !seen_q && !pulse_now &&
                    silent_q == SILENT_LAST) begin
                    state_d = LINE_SILENT;
                    change  = 1'b1;
                end
            end
            LINE_SILENT: begin
                if (pulse_now) begin
                    state_d  = LINE_ACTIVE;
                    silent_d = 8'h00;
                    change   = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q  <= LINE_ACTIVE;
            silent_q <= 8'h00;
            seen_q   <= 1'b0;
        end else begin
            state_q  <= state_d;
            silent_q <= silent_d;
            seen_q   <= seen_d;
        end
    end

    assign drive_fault = (state_q == LINE_SILENT);

    // AXI4-Lite write channel: address and data taken in either order.
    logic        aw_held_q, aw_held_d;
    logic [15:0] awaddr_q, awaddr_d;
    logic        w_held_q, w_held_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0]  wstrb_q, wstrb_d;
    logic        bvalid_q, bvalid_d;
    logic [1:0]  bresp_q, bresp_d;
    logic        do_write;
    logic        wr_low;
    logic [15:0] wr_idx;

    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready  = !w_held_q && !bvalid_q;
    assign do_write      = aw_held_q && w_held_q && !bvalid_q;
    assign wr_idx        = reg_index(awaddr_q);
    assign wr_low        = do_write && is_mapped(awaddr_q) && wstrb_q[0];

    always_comb begin
        aw_held_d = aw_held_q;
        awaddr_d  = awaddr_q;
        w_held_d  = w_held_q;
        wdata_d   = wdata_q;
        wstrb_d   = wstrb_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_held_d = 1'b1;
            awaddr_d  = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_held_d = 1'b1;
            wdata_d  = s_axi_wdata;
            wstrb_d  = s_axi_wstrb;
        end
        if (do_write) begin
            aw_held_d = 1'b0;
            w_held_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = is_mapped(awaddr_q) ? `RESP_OKAY : `RESP_SLVERR;
        end else if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            awaddr_q  <= 16'h0000;
            w_held_q  <= 1'b0;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= `RESP_OKAY;
        end else begin
            aw_held_q <= aw_held_d;
            awaddr_q  <= awaddr_d;
            w_held_q  <= w_held_d;
            wdata_q   <= wdata_d;
            wstrb_q   <= wstrb_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp  = bresp_q;

    // AXI4-Lite read channel: one read under way, answer on the next edge.
    logic        rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0]  rresp_q, rresp_d;
    logic        rd_take;
    logic        rd_flags;
    logic [15:0] rd_idx;

    assign s_axi_arready = !rvalid_q;
    assign rd_take       = s_axi_arvalid && s_axi_arready;
    assign rd_idx        = reg_index(s_axi_araddr);
    assign rd_flags      = rd_take && is_mapped(s_axi_araddr) && rd_idx == `IDX_IRQ_FLAGS;

    always_comb begin
        rvalid_d = rvalid_q;
        rdata_d  = rdata_q;
        rresp_d  = rresp_q;
        if (rd_take) begin
            rvalid_d = 1'b1;
            rdata_d  = 32'h0000_0000;
            rresp_d  = is_mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
            if (is_mapped(s_axi_araddr)) begin
                unique case (rd_idx)
                    `IDX_IRQ_FLAGS:   rdata_d[`BIT_DRIVE_CHANGE] = flag_q;
                    `IDX_ALARM_STATE: rdata_d[`BIT_DRIVE_FAULT]  = drive_fault;
                    `IDX_TX_CONTROL: begin
                        rdata_d[`BIT_INTERNAL_MON] = ctrl_q.internal_mon;
                        rdata_d[`BIT_SEND_ONES]    = ctrl_q.send_all_ones;
                        rdata_d[`BIT_BUILD_OUT]    = ctrl_q.build_out_disable;
                    end
                    default:          rdata_d[`BIT_DRIVE_CHANGE] = mask_q;
                endcase
            end
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= `RESP_OKAY;
        end else begin
            rvalid_q <= rvalid_d;
            rdata_q  <= rdata_d;
            rresp_q  <= rresp_d;
        end
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata  = rdata_q;
    assign s_axi_rresp  = rresp_q;

    // Control, mask and change flag registers.
    assign mode_write = wr_low && wr_idx == `IDX_TX_CONTROL &&
                        wdata_q[`BIT_INTERNAL_MON] != ctrl_q.internal_mon;

    always_comb begin
        ctrl_d = ctrl_q;
        mask_d = mask_q;
        flag_d = flag_q;
        if (wr_low && wr_idx == `IDX_TX_CONTROL) begin
            ctrl_d.internal_mon      = wdata_q[`BIT_INTERNAL_MON];
            ctrl_d.send_all_ones     = wdata_q[`BIT_SEND_ONES];
            ctrl_d.build_out_disable = wdata_q[`BIT_BUILD_OUT];
        end
        if (wr_low && wr_idx == `IDX_IRQ_MASK) begin
            mask_d = wdata_q[`BIT_DRIVE_CHANGE];
        end
        if (wr_low && wr_idx == `IDX_IRQ_FLAGS && wdata_q[`BIT_DRIVE_CHANGE]) begin
            flag_d = 1'b0;
        end
        if (rd_flags) begin
            // Only the value handed back is cleared; a set in this cycle survives.
            flag_d = 1'b0;
        end
        if (change) begin
            flag_d = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= tx_ctrl_t'({TX_CTRL_RST[`BIT_INTERNAL_MON],
                                  TX_CTRL_RST[`BIT_SEND_ONES],
                                  TX_CTRL_RST[`BIT_BUILD_OUT]});
            mask_q <= IRQ_MASK_RST[`BIT_DRIVE_CHANGE];
            flag_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            mask_q <= mask_d;
            flag_q <= flag_d;
        end
    end

    assign build_out_disable = ctrl_q.build_out_disable;
    assign send_all_ones     = ctrl_q.send_all_ones;

    // The request follows the flag and mask flops, so it never glitches on bus traffic.
    assign irq_n = !(flag_q && mask_q);

endmodule : transmit_drive_monitor

// ===== tb/drive_monitor_asserts.sv
// Concurrent checks on the ports of the transmit drive monitor.
// Assumes it is bound into transmit_drive_monitor and that the mask stays set
// whenever a change flag is left pending.
`timescale 1ns/10ps
module drive_monitor_asserts (
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Register bus
    input wire logic [15:0] s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    // Line senses
    input wire logic        monitor_pos_in,
    input wire logic        monitor_neg_in,
    input wire logic        line_out_pos,
    input wire logic        line_out_neg,
    // Status
    input wire logic        drive_fault,
    input wire logic        irq_n
);
    logic [7:0] pin_q, pin_d, pad_q, pad_d;
    logic       pin_hit, pad_hit;
    assign pin_hit = monitor_pos_in | monitor_neg_in;
    assign pad_hit = line_out_pos | line_out_neg;
    // Silence run lengths saturate so a long quiet stretch never wraps to zero.
    always_comb begin
        pin_d = pin_hit ? 8'h00 : pin_q + {7'h00, pin_q != 8'hff};
        pad_d = pad_hit ? 8'h00 : pad_q + {7'h00, pad_q != 8'hff};
    end
    always_ff @(posedge aclk) begin
        pin_q <= aresetn ? pin_d : 8'h00;
        pad_q <= aresetn ? pad_d : 8'h00;
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_silence_declares: assert property (
        pin_q >= 8'd140 && pad_q >= 8'd140 |-> drive_fault) else $error("fault not declared");
    a_no_early_fault: assert property (
        $rose(drive_fault) |-> pin_q >= 8'd126 || pad_q >= 8'd126) else $error("early fault");
    a_pulse_clears: assert property (
        drive_fault && pin_hit && pad_hit |-> ##[1:4] !drive_fault) else $error("fault kept");
    a_fault_holds: assert property (
        drive_fault && pin_q >= 8'd4 && pad_q >= 8'd4 |=> drive_fault) else $error("fault lost");
    a_irq_cause: assert property (
        $fell(irq_n) |-> $changed(drive_fault)) else $error("irq without change");
    a_read_releases: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr == 16'h4c08
        |-> ##[1:3] (irq_n || $changed(drive_fault))) else $error("irq not released");
    a_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("late read data");
    a_rdata_stands: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_bresp_stands: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    c_declare: cover property ($rose(drive_fault));
    c_clear: cover property ($fell(drive_fault));
    c_release: cover property ($rose(irq_n));
endmodule : drive_monitor_asserts

bind transmit_drive_monitor drive_monitor_asserts chk (.*);

// ===== tb/line_model.sv
// Transmit line with its optional loop back to the monitor input pins.
// Assumes the bench gates activity and the loop; an open loop reads low,
// as the pins are then pulled to ground.
`timescale 1ns/10ps
module line_model (
    // Clock and controls
    input wire logic aclk,
    input wire logic active,
    input wire logic loop,
    // Line senses
    output logic     mon_pos,
    output logic     mon_neg,
    output logic     pad_pos,
    output logic     pad_neg
);
    logic [2:0] ph_q = 3'h0;
    always_ff @(posedge aclk) ph_q <= ph_q + 3'h1;
    // Marks alternate in polarity, as a bipolar line does.
    assign pad_pos = active && ph_q == 3'h0;
    assign pad_neg = active && ph_q == 3'h4;
    assign mon_pos = loop && pad_pos;
    assign mon_neg = loop && pad_neg;
endmodule : line_model

// ===== tb/tb_transmit_drive_monitor.sv
// Self-checking bench for the transmit drive monitor.
// Assumes the line model stands for the transmit line and its loop back.
`timescale 1ns/10ps
`include "drive_monitor_map.svh"
module tb_transmit_drive_monitor;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [15:0] aw_addr = 16'h0, ar_addr = 16'h0;
    logic [31:0] w_data = 32'h0, rdata, d;
    logic        aw_valid = 1'b0, w_valid = 1'b0, b_ready = 1'b0;
    logic        ar_valid = 1'b0, r_ready = 1'b0, act = 1'b1, loop = 1'b1;
    logic        aw_ready, w_ready, b_valid, ar_ready, r_valid;
    logic [1:0]  bresp, rresp, r;
    logic        mon_p, mon_n, pad_p, pad_n, bod, sao, drive_fault, irq_n;
    int          n, fail_count = 0, tests_run = 0;
    always #10 aclk = ~aclk;
    transmit_drive_monitor uut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(aw_addr), .s_axi_awprot(3'h0), .s_axi_awvalid(aw_valid),
        .s_axi_awready(aw_ready), .s_axi_wdata(w_data), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(w_valid), .s_axi_wready(w_ready), .s_axi_bresp(bresp),
        .s_axi_bvalid(b_valid), .s_axi_bready(b_ready), .s_axi_araddr(ar_addr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(ar_valid), .s_axi_arready(ar_ready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(r_valid),
        .s_axi_rready(r_ready), .monitor_pos_in(mon_p), .monitor_neg_in(mon_n),
        .line_out_pos(pad_p), .line_out_neg(pad_n), .build_out_disable(bod),
        .send_all_ones(sao), .drive_fault(drive_fault), .irq_n(irq_n));
    line_model lm (.aclk(aclk), .active(act), .loop(loop), .mon_pos(mon_p),
        .mon_neg(mon_n), .pad_pos(pad_p), .pad_neg(pad_n));
    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_sim
    task automatic hang();
        fail_count++;
        end_sim();
    endtask : hang
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, input logic [31:0] v);
        int k;
        @(posedge aclk);
        aw_addr <= a;
        w_data <= v;
        aw_valid <= 1'b1;
        w_valid <= 1'b1;
        b_ready <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge aclk);
            if (aw_valid && aw_ready) aw_valid <= 1'b0;
            if (w_valid && w_ready) w_valid <= 1'b0;
            if (b_valid) break;
        end
        if (k == 50) hang();
        r = bresp;
        b_ready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [15:0] a);
        int k;
        @(posedge aclk);
        ar_addr <= a;
        ar_valid <= 1'b1;
        r_ready <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge aclk);
            if (ar_valid && ar_ready) ar_valid <= 1'b0;
            if (r_valid) break;
        end
        if (k == 50) hang();
        d = rdata;
        r = rresp;
        r_ready <= 1'b0;
    endtask : rd
    // Waits for the fault level v, counting edges in n.
    task automatic wf(input logic v);
        n = 0;
        while (drive_fault !== v && n < 400) begin
            @(posedge aclk);
            n++;
        end
        if (n == 400) hang();
    endtask : wf
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk("irq_n", irq_n, 1);
        chk("fault", drive_fault, 0);
        rd(16'h4c10);
        chk("tx", d, 0);
        chk("rresp", r, `RESP_OKAY);
        rd(16'h4c14);
        chk("mask", d, 1);
        rd(16'h4c0c);
        chk("alarm", d, 0);
        rd(16'h4c20);
        chk("unmapped", {d[29:0], r}, {30'h0, `RESP_SLVERR});
        wr(16'h4c20, 32'h01);
        chk("bresp", r, `RESP_SLVERR);
        wr(16'h4c10, 32'h05);
        chk("bresp", r, `RESP_OKAY);
        chk("controls", {30'h0, bod, sao}, 3);
        rd(16'h4c10);
        chk("tx", d, 32'h05);
        wr(16'h4c10, 32'h00);
        repeat (300) @(posedge aclk);
        chk("busy line", drive_fault, 0);
        act <= 1'b0;
        wf(1'b1);
        chk("silence", n >= 128 && n <= 131, 1);
        chk("irq_n", irq_n, 0);
        rd(16'h4c0c);
        chk("alarm", d, 1);
        rd(16'h4c08);
        chk("flags", d, 1);
        repeat (2) @(posedge aclk);
        chk("irq_n", irq_n, 1);
        rd(16'h4c08);
        chk("flags", d, 0);
        act <= 1'b1;
        wf(1'b0);
        chk("clear", n >= 4 && n <= 7, 1);
        chk("irq_n", irq_n, 0);
        rd(16'h4c0c);
        chk("alarm", d, 0);
        rd(16'h4c08);
        chk("flags", d, 1);
        wr(16'h4c10, 32'h20);
        loop <= 1'b0;
        repeat (300) @(posedge aclk);
        chk("pads", drive_fault, 0);
        wr(16'h4c10, 32'h00);
        wf(1'b1);
        chk("pins", drive_fault, 1);
        wr(16'h4c14, 32'h00);
        wr(16'h4c08, 32'h01);
        chk("irq_n", irq_n, 1);
        rd(16'h4c08);
        chk("flags", d, 0);
        wr(16'h4c10, 32'h20);
        wf(1'b0);
        chk("masked", irq_n, 1);
        rd(16'h4c08);
        chk("flags", d, 1);
        wr(16'h4c14, 32'h01);
        chk("irq_n", irq_n, 1);
        end_sim();
    end
endmodule : tb_transmit_drive_monitor
